// *** bench/apsc_mem_model.sv ***
// Behavioural pseudo-static memory answering the host pins
`timescale 1ns/100ps
`default_nettype none
module apsc_mem_model #(
  parameter int TCE = 60,
  parameter int TAA = 60,
  parameter int TOE = 35,
  parameter int TASO = 25
) (
  input  wire logic        chip_select_n,
  input  wire logic        write_n,
  input  wire logic        output_en_n,
  input  wire logic        lower_byte_n,
  input  wire logic        upper_byte_n,
  input  wire logic        power_keep_enable,
  input  wire logic [19:0] mem_addr,
  input  wire logic [15:0] dq_bus,
  output logic      [15:0] dq_drv
);
  logic [15:0] mem [int];
  logic [15:0] lat_d;
  logic [15:0] old;
  logic [15:0] last_q = 16'h0000;
  logic [19:0] lat_a;
  logic [19:0] prev_a = 20'h00000;
  logic [1:0]  lat_l;
  logic        prev_cs = 1'b1;
  logic        rd_mode = 1'b0;
  logic        wr_prev = 1'b0;
  logic        active;
  logic        tick = 1'b0;
  realtime     t_sel = 0;
  realtime     t_pg = 0;
  realtime     t_oe = 0;
  logic        prev_oe = 1'b1;
  // ****************************************
  // Pin sampler
  // ****************************************
  // Pins are seen up to 1 ns late, so data never shows earlier than on real parts
  always #1 begin
    tick = ~tick;
    if (prev_cs && !chip_select_n) begin
      t_sel = $realtime;
      rd_mode = !output_en_n;
    end
    if (!chip_select_n && mem_addr[19:3] != prev_a[19:3]) t_sel = $realtime;
    else if (!chip_select_n && mem_addr[2:0] != prev_a[2:0]) t_pg = $realtime;
    active = !chip_select_n && !write_n && !rd_mode && power_keep_enable;
    if (active) begin
      lat_a = mem_addr;
      lat_d = dq_bus;
      lat_l = {upper_byte_n, lower_byte_n};
    end
    if (wr_prev && !active) begin
      old = mem.exists(int'(lat_a)) ? mem[int'(lat_a)] : 16'hxxxx;
      mem[int'(lat_a)] = {lat_l[1] ? old[15:8] : lat_d[15:8], lat_l[0] ? old[7:0] : lat_d[7:0]};
    end
    if (prev_oe && !output_en_n) t_oe = $realtime;
    // Address setup to the enable is taken as zero, so the whole reference setup lengthens it
    if (!chip_select_n && !output_en_n && write_n && power_keep_enable && $realtime >= t_sel + TCE
        && $realtime >= t_oe + TOE + TASO
        && $realtime >= t_pg + TAA && mem.exists(int'(mem_addr))) begin
      dq_drv = mem[int'(mem_addr)];
      last_q = dq_drv;
    end else begin
      dq_drv = ~last_q ^ {16{tick}};
    end
    prev_a = mem_addr;
    prev_cs = chip_select_n;
    prev_oe = output_en_n;
    wr_prev = active;
  end
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
// Self-checking bench for the memory host sequencer
`timescale 1ns/100ps
`default_nettype none
`include "apsc_params.svh"
module testbench;
  logic        clk = 1'b0;
  logic        rst_n;
  logic        req_valid, req_write, req_ready, rd_valid;
  logic [19:0] req_addr, mem_addr;
  logic [15:0] req_wdata, rd_data, dq_o, dq_drv, dq_bus;
  logic [1:0]  req_byte_n;
  logic        chip_select_n, write_n, output_en_n, lower_byte_n, upper_byte_n, power_keep_enable, dq_oe;
  logic [15:0] ref_mem [int];
  logic [15:0] exp_q [$];
  logic [19:0] a [8];
  logic [19:0] base;
  int          errors = 0;
  int          num_checks = 0;
  integer      seed;
  int          i, n;
  realtime     t_fall = 0;
  realtime     t_rise = 0;
  realtime     t_oe = 0;
  logic        is_wr = 1'b0;
  logic        was_wr = 1'b0;
  always #2.5 clk = ~clk;
  assign dq_bus = (dq_oe === 1'b1) ? dq_o : dq_drv;
  apsc_ctrl #(.SLOW_GRADE(1'b0)) i_apsc_ctrl (
    .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_byte_n(req_byte_n), .req_ready(req_ready), .rd_valid(rd_valid),
    .rd_data(rd_data), .chip_select_n(chip_select_n), .write_n(write_n), .output_en_n(output_en_n),
    .lower_byte_n(lower_byte_n), .upper_byte_n(upper_byte_n), .power_keep_enable(power_keep_enable),
    .mem_addr(mem_addr), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_bus));
  apsc_mem_model #(.TCE(`APSC_TCE_F), .TAA(`APSC_TAA_F)) i_apsc_mem_model (
    .chip_select_n(chip_select_n), .write_n(write_n), .output_en_n(output_en_n),
    .lower_byte_n(lower_byte_n), .upper_byte_n(upper_byte_n), .power_keep_enable(power_keep_enable),
    .mem_addr(mem_addr), .dq_bus(dq_bus), .dq_drv(dq_drv));
  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] d, input logic [1:0] bn);
    merge = {bn[1] ? o[15:8] : d[15:8], bn[0] ? o[7:0] : d[7:0]};
  endfunction
  // ****************************************
  // Request driver
  // ****************************************
  task automatic issue(input logic w, input logic [19:0] ad, input logic [15:0] d, input logic [1:0] bn);
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (req_ready !== 1'b1 && k < 400);
    if (k >= 400) begin
      errors++;
      wrap_up;
    end
    req_valid = 1'b1;
    req_write = w;
    req_addr = ad;
    req_wdata = d;
    req_byte_n = bn;
    @(negedge clk);
    req_valid = 1'b0;
  endtask
  task automatic wr(input logic [19:0] ad, input logic [15:0] d, input logic [1:0] bn);
    ref_mem[int'(ad)] = merge(ref_mem.exists(int'(ad)) ? ref_mem[int'(ad)] : 16'hxxxx, d, bn);
    issue(1'b1, ad, d, bn);
  endtask
  task automatic rd(input logic [19:0] ad);
    exp_q.push_back(ref_mem[int'(ad)]);
    issue(1'b0, ad, 16'h0000, 2'b00);
  endtask
  // ****************************************
  // Monitors
  // ****************************************
  always @(negedge clk) begin
    if (rd_valid === 1'b1 && exp_q.size() == 0) check("spare_rd_valid", 1, 0);
    else if (rd_valid === 1'b1) check("rd_data", rd_data, exp_q.pop_front());
  end
  always @(negedge output_en_n) t_oe = $realtime;
  always @(negedge chip_select_n) begin
    if (t_rise > 0) check("cs_high_ns", ($realtime - t_rise) >= `APSC_TCP_F, 1);
    if (was_wr) check("write_cycle_ns", ($realtime - t_fall) >= `APSC_TWC_F, 1);
    check("power_keep", power_keep_enable, 1);
    t_fall = $realtime;
    is_wr = (write_n === 1'b0);
  end
  always @(posedge chip_select_n) begin
    if (t_fall > 0 && is_wr) check("write_pulse_ns", ($realtime - t_fall) >= `APSC_TCW_F, 1);
    if (t_fall > 0 && !is_wr) check("oe_to_cs_ns", ($realtime - t_oe) >= `APSC_TOLCH_F, 1);
    if (t_fall > 0) check("cs_low_max_ns", ($realtime - t_fall) <= `APSC_TMAXLOW_NS, 1);
    was_wr = is_wr;
    t_rise = $realtime;
  end
  initial begin
    #400000;
    errors++;
    wrap_up;
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed = 32'ha4ad;
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 20'h00000;
    req_wdata = 16'h0000;
    req_byte_n = 2'b00;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    for (i = 0; i < 8; i++) begin
      a[i] = 20'($random(seed));
      wr(a[i], 16'($random(seed)), 2'b00);
    end
    // Every lane pattern, including a write that touches no lane
    for (i = 0; i < 4; i++) wr(a[i], 16'($random(seed)), 2'(i));
    for (i = 0; i < 8; i++) rd(a[i]);
    for (i = 0; i < 24; i++) begin
      n = $random(seed);
      if (n[0]) wr(a[n[3:1]], 16'($random(seed)), 2'(n[5:4]));
      else rd(a[n[3:1]]);
    end
    // Page hits switching one, two and three offset bits
    base = {a[0][19:3] ^ 17'h1a5a5, 3'h0};
    for (i = 0; i < 8; i++) wr(base | 20'(i), 16'($random(seed)), 2'b00);
    foreach (a[j]) rd(base | 20'(j ^ 3));
    rd(base | 20'h00006);
    rd(base | 20'h00006);
    // Idle open page must close on its own before the low limit
    repeat (200) @(negedge clk);
    rd(a[5]);
    wr(a[5], 16'hc3a5, 2'b10);
    rd(a[5]);
    n = 0;
    while (exp_q.size() > 0 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    check("reads_left", exp_q.size(), 0);
    wrap_up;
  end
endmodule
`default_nettype wire

// *** design/apsc_ctrl.sv ***
// Host sequencer driving an asynchronous pseudo-static memory over its SRAM-style pins
// How it works
// - Keep absolute enable setup and pulse minimums
// - Hold low address one read cycle after select
// - Short enable spacing extends address hold
// - Select stays low after enable falls
// - Select high pulse between accesses kept
// - Low-select intervals never exceed 1000 ns
// - Write strobe low for write pulse minimum
// - Write cycle meets minimum and pulse sum
// - Terminating strobe high for write recovery
// - Early select rise also meets select recovery
// - Strobe-terminated write setup sums reach 60 ns
// - Late enable release delays write strobe
// - Enable held high after strobe-terminated write
// - Power keep enable high during every access
`timescale 1ns/100ps
`default_nettype none
`include "apsc_params.svh"
module apsc_ctrl #(
  parameter bit SLOW_GRADE = 1'b0
) (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    req_valid,
  input  wire logic                    req_write,
  input  wire logic [`APSC_ADDR_W-1:0] req_addr,
  input  wire logic [`APSC_DATA_W-1:0] req_wdata,
  input  wire logic [1:0]              req_byte_n,
  output logic                         req_ready,
  output logic                         rd_valid,
  output logic [`APSC_DATA_W-1:0]      rd_data,
  output logic                         chip_select_n,
  output logic                         write_n,
  output logic                         output_en_n,
  output logic                         lower_byte_n,
  output logic                         upper_byte_n,
  output logic                         power_keep_enable,
  output logic [`APSC_ADDR_W-1:0]      mem_addr,
  output logic [`APSC_DATA_W-1:0]      dq_o,
  output logic                         dq_oe,
  input  wire logic [`APSC_DATA_W-1:0] dq_i
);
  // ****************************************
  // Cycle counts
  // ****************************************
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + `APSC_CLK_NS - 1) / `APSC_CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int CE_CYC    = cyc_up(SLOW_GRADE ? `APSC_TCE_S : `APSC_TCE_F);
  localparam int AA_CYC    = cyc_up(SLOW_GRADE ? `APSC_TAA_S : `APSC_TAA_F);
  localparam int CLAH_CYC  = cyc_up(SLOW_GRADE ? `APSC_TRC_S : `APSC_TRC_F);
  localparam int OLCH_CYC  = cyc_up(SLOW_GRADE ? `APSC_TOLCH_S : `APSC_TOLCH_F);
  localparam int CP_CYC    = cyc_up(SLOW_GRADE ? `APSC_TCP_S : `APSC_TCP_F);
  localparam int CHZ_CYC   = cyc_up(SLOW_GRADE ? `APSC_TCHZ_S : `APSC_TCHZ_F);
  localparam int CW_CYC    = cyc_up(SLOW_GRADE ? `APSC_TCW_S : `APSC_TCW_F);
  localparam int WRC_CYC   = cyc_up(`APSC_TWRC_NS);
  localparam int WC_CYC    = cyc_up(SLOW_GRADE ? `APSC_TWC_S : `APSC_TWC_F);
  localparam int MAXLO_CYC = `APSC_TMAXLOW_NS / `APSC_CLK_NS;
  localparam int PGLIM_CYC = `APSC_PAGE_LIMIT_NS / `APSC_CLK_NS;
  localparam int SMP_CE_I  = CE_CYC + `APSC_SYNC_STAGES;
  localparam int SMP_AA_I  = AA_CYC + `APSC_SYNC_STAGES;
  localparam int RDGAP_I   = (CHZ_CYC > CP_CYC) ? CHZ_CYC : CP_CYC;
  localparam int WRGAP_I   = (WRC_CYC > WC_CYC - CW_CYC - 1) ? WRC_CYC : WC_CYC - CW_CYC - 1;
  localparam int HI        = `APSC_ADDR_W - 1;

  localparam apsc_pkg::apsc_cnt_t SMP_CE = apsc_pkg::apsc_cnt_t'(SMP_CE_I);
  localparam apsc_pkg::apsc_cnt_t SMP_AA = apsc_pkg::apsc_cnt_t'(SMP_AA_I);
  localparam apsc_pkg::apsc_cnt_t CLAH_C = apsc_pkg::apsc_cnt_t'(CLAH_CYC);
  localparam apsc_pkg::apsc_cnt_t PGLIM  = apsc_pkg::apsc_cnt_t'(PGLIM_CYC);
  localparam apsc_pkg::apsc_cnt_t CW_END = apsc_pkg::apsc_cnt_t'(CW_CYC - 1);
  localparam apsc_pkg::apsc_cnt_t RD_GAP = apsc_pkg::apsc_cnt_t'(RDGAP_I - 1);
  localparam apsc_pkg::apsc_cnt_t WR_GAP = apsc_pkg::apsc_cnt_t'(WRGAP_I - 1);

  if (PGLIM_CYC + SMP_AA_I + 2 >= MAXLO_CYC || MAXLO_CYC > 254 || OLCH_CYC > SMP_CE_I)
    $error("apsc_ctrl: timing counts do not fit the sequencer");

  // ****************************************
  // Timer, synchroniser and decode
  // ****************************************
  apsc_tmr_if tmr ();
  apsc_timer u_timer (
    .clk   (clk),
    .rst_n (rst_n),
    .t     (tmr)
  );

  apsc_pkg::apsc_state_e          st_r, st_nxt;
  logic [`APSC_DATA_W-1:0]        dq_meta_r, dq_sync_r;
  logic                           pend_r, pend_nxt;
  logic                           cmd_we_r;
  logic [`APSC_ADDR_W-1:0]        cmd_addr_r;
  logic [`APSC_DATA_W-1:0]        cmd_wdata_r;
  logic [1:0]                     cmd_byte_r;
  apsc_pkg::apsc_cnt_t            gap_r, gap_nxt;
  logic                           cs_nxt, we_nxt, oe_nxt, lo_lane_nxt, hi_lane_nxt, oen_nxt, rv_nxt, rdy_nxt;
  logic [`APSC_ADDR_W-1:0]        addr_nxt;
  logic [`APSC_DATA_W-1:0]        dqo_nxt, rdat_nxt;
  logic                           phase_clr;

  wire accept    = req_valid & req_ready;
  wire page_hit  = pend_r & ~cmd_we_r &
                   (cmd_addr_r[HI:`APSC_PAGE_BITS] == mem_addr[HI:`APSC_PAGE_BITS]);
  wire page_tout = tmr.age >= PGLIM;
  wire hold_ok   = tmr.age >= CLAH_C;

  assign tmr.phase_clr = phase_clr;
  assign tmr.cs_low    = ~chip_select_n;

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    st_nxt    = st_r;
    pend_nxt  = pend_r | accept;
    gap_nxt   = gap_r;
    cs_nxt    = chip_select_n;
    we_nxt    = write_n;
    oe_nxt    = output_en_n;
    lo_lane_nxt = lower_byte_n;
    hi_lane_nxt = upper_byte_n;
    oen_nxt   = dq_oe;
    addr_nxt  = mem_addr;
    dqo_nxt   = dq_o;
    rdat_nxt  = rd_data;
    rv_nxt    = 1'b0;
    phase_clr = 1'b0;
    case (st_r)
      apsc_pkg::ST_IDLE: begin
        if (pend_r) begin
          pend_nxt  = 1'b0;
          phase_clr = 1'b1;
          addr_nxt  = cmd_addr_r;
          lo_lane_nxt = cmd_byte_r[0];
          hi_lane_nxt = cmd_byte_r[1];
          if (cmd_we_r) begin
            we_nxt  = 1'b0;
            dqo_nxt = cmd_wdata_r;
            oen_nxt = 1'b1;
            st_nxt  = apsc_pkg::ST_WSET;
          end else begin
            cs_nxt  = 1'b0;
            oe_nxt  = 1'b0;
            st_nxt  = apsc_pkg::ST_RSTB;
          end
        end
      end
      apsc_pkg::ST_RSTB: begin
        if (tmr.phase == SMP_CE) begin
          rdat_nxt  = dq_sync_r;
          rv_nxt    = 1'b1;
          st_nxt    = apsc_pkg::ST_PAGE;
        end
      end
      apsc_pkg::ST_PAGE: begin
        // An aged page refuses further hits, so a stream of hits cannot outlast the low limit
        if (page_hit && !page_tout) begin
          st_nxt    = apsc_pkg::ST_PGHOLD;
        end else if (pend_r || page_tout) begin
          cs_nxt    = 1'b1;
          oe_nxt    = 1'b1;
          lo_lane_nxt = `APSC_PIN_IDLE;
          hi_lane_nxt = `APSC_PIN_IDLE;
          phase_clr = 1'b1;
          gap_nxt   = RD_GAP;
          st_nxt    = apsc_pkg::ST_CLOSE;
        end
      end
      apsc_pkg::ST_PGHOLD: begin
        if (hold_ok) begin
          addr_nxt  = cmd_addr_r;
          lo_lane_nxt = cmd_byte_r[0];
          hi_lane_nxt = cmd_byte_r[1];
          pend_nxt  = 1'b0;
          phase_clr = 1'b1;
          st_nxt    = apsc_pkg::ST_PGRD;
        end
      end
      apsc_pkg::ST_PGRD: begin
        // Sampling only after the full access time also hides the early invalid window
        if (tmr.phase == SMP_AA) begin
          rdat_nxt  = dq_sync_r;
          rv_nxt    = 1'b1;
          st_nxt    = apsc_pkg::ST_PAGE;
        end
      end
      apsc_pkg::ST_WSET: begin
        cs_nxt    = 1'b0;
        phase_clr = 1'b1;
        st_nxt    = apsc_pkg::ST_WSTB;
      end
      apsc_pkg::ST_WSTB: begin
        // Writes always end on the select, so the strobe-terminated cases never arise
        if (tmr.phase == CW_END) begin
          cs_nxt    = 1'b1;
          we_nxt    = 1'b1;
          oen_nxt   = 1'b0;
          lo_lane_nxt = `APSC_PIN_IDLE;
          hi_lane_nxt = `APSC_PIN_IDLE;
          phase_clr = 1'b1;
          gap_nxt   = WR_GAP;
          st_nxt    = apsc_pkg::ST_CLOSE;
        end
      end
      apsc_pkg::ST_CLOSE: begin
        if (tmr.phase == gap_r) begin
          st_nxt    = apsc_pkg::ST_IDLE;
        end
      end
      default: begin
        st_nxt    = apsc_pkg::ST_IDLE;
      end
    endcase
    rdy_nxt = ((st_nxt == apsc_pkg::ST_IDLE) || (st_nxt == apsc_pkg::ST_PAGE)) & ~pend_nxt;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r              <= apsc_pkg::ST_IDLE;
      pend_r            <= 1'b0;
      gap_r             <= 8'h00;
      chip_select_n     <= `APSC_PIN_IDLE;
      write_n           <= `APSC_PIN_IDLE;
      output_en_n       <= `APSC_PIN_IDLE;
      lower_byte_n      <= `APSC_PIN_IDLE;
      upper_byte_n      <= `APSC_PIN_IDLE;
      power_keep_enable <= 1'b0;
      dq_oe             <= 1'b0;
      req_ready         <= 1'b0;
      rd_valid          <= 1'b0;
    end else begin
      st_r              <= st_nxt;
      pend_r            <= pend_nxt;
      gap_r             <= gap_nxt;
      chip_select_n     <= cs_nxt;
      write_n           <= we_nxt;
      output_en_n       <= oe_nxt;
      lower_byte_n      <= lo_lane_nxt;
      upper_byte_n      <= hi_lane_nxt;
      power_keep_enable <= 1'b1;
      dq_oe             <= oen_nxt;
      req_ready         <= rdy_nxt;
      rd_valid          <= rv_nxt;
    end
  end

  // Data path carries no control meaning, so it needs no reset
  always_ff @(posedge clk) begin
    dq_meta_r <= dq_i;
    dq_sync_r <= dq_meta_r;
    mem_addr  <= addr_nxt;
    dq_o      <= dqo_nxt;
    rd_data   <= rdat_nxt;
    if (accept) begin
      cmd_we_r    <= req_write;
      cmd_addr_r  <= req_addr;
      cmd_wdata_r <= req_wdata;
      cmd_byte_r  <= req_byte_n;
    end
  end

  // ****************************************
  // Pin timing checks
  // ****************************************
  logic                cs_d_r, last_wr_r;
  apsc_pkg::apsc_cnt_t hi_age_r, prd_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cs_d_r    <= 1'b1;
      last_wr_r <= 1'b0;
      hi_age_r  <= 8'hff;
      prd_r     <= 8'hff;
    end else begin
      cs_d_r    <= chip_select_n;
      last_wr_r <= chip_select_n ? last_wr_r : ~write_n;
      hi_age_r  <= !chip_select_n ? 8'h00 : (hi_age_r == 8'hff) ? hi_age_r : hi_age_r + 8'h01;
      prd_r     <= (cs_d_r & ~chip_select_n) ? 8'h00 : (prd_r == 8'hff) ? prd_r : prd_r + 8'h01;
    end
  end

  a_cs_high_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(chip_select_n) |-> $past(hi_age_r) >= CP_CYC - 1) else $error("select high pulse too short");
  a_wr_recovery: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(chip_select_n) && last_wr_r |-> $past(hi_age_r) >= WRC_CYC - 1) else $error("write recovery too short");
  a_wr_cycle_len: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(chip_select_n) && last_wr_r |-> prd_r >= WC_CYC - 1) else $error("write cycle too short");
  a_wr_pulse_len: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(chip_select_n) && $past(!write_n) |-> $past(tmr.age) >= CW_CYC - 1) else $error("write pulse too short");
  a_oe_to_desel: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(chip_select_n) && $past(!output_en_n) |-> $past(tmr.age) >= OLCH_CYC - 1)
    else $error("select rose too soon after enable");
  a_page_addr_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !chip_select_n && $past(!chip_select_n) && $changed(mem_addr[2:0]) |-> tmr.age > CLAH_C)
    else $error("page address changed too early");
  a_low_max_time: assert property (@(posedge clk) disable iff (!rst_n)
    !chip_select_n |-> tmr.age < MAXLO_CYC) else $error("select held low too long");
  a_wr_needs_oe_hi: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(chip_select_n) && !write_n |-> $past(output_en_n) && output_en_n)
    else $error("write started with output enable low");
  a_power_kept: assert property (@(posedge clk) disable iff (!rst_n)
    !chip_select_n |-> power_keep_enable && $past(power_keep_enable)) else $error("power enable low in access");
  a_rd_sample_time: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(rd_valid) && $past(st_r) == apsc_pkg::ST_RSTB |-> $past(tmr.age, 2) == SMP_CE - 1)
    else $error("read sampled at wrong time");
endmodule
`default_nettype wire

// *** design/apsc_params.svh ***
// Timing, width and reset constants for the asynchronous pseudo-static memory host
`ifndef APSC_PARAMS_SVH
`define APSC_PARAMS_SVH

`define APSC_CLK_NS        5
`define APSC_ADDR_W        20
`define APSC_DATA_W        16
`define APSC_PAGE_BITS     3
`define APSC_SYNC_STAGES   2
`define APSC_PIN_IDLE      1'b1

// Fast grade (_F), slow grade (_S) and grade-independent (_NS) figures in ns
`define APSC_TCE_F         60
`define APSC_TCE_S         70
`define APSC_TAA_F         60
`define APSC_TAA_S         70
`define APSC_TRC_F         80
`define APSC_TRC_S         90
`define APSC_TOLCH_F       45
`define APSC_TOLCH_S       50
`define APSC_TCP_F         10
`define APSC_TCP_S         12
`define APSC_TCHZ_F        20
`define APSC_TCHZ_S        25
`define APSC_TCW_F         45
`define APSC_TCW_S         50
`define APSC_TWRC_NS       20
`define APSC_TWC_F         80
`define APSC_TWC_S         90
`define APSC_TMAXLOW_NS    1000
`define APSC_PAGE_LIMIT_NS 800

`endif

// *** design/apsc_pkg.sv ***
// Types shared by the memory host modules
`default_nettype none
package apsc_pkg;
  typedef logic [7:0] apsc_cnt_t;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RSTB,
    ST_PAGE,
    ST_PGHOLD,
    ST_PGRD,
    ST_WSET,
    ST_WSTB,
    ST_CLOSE
  } apsc_state_e;
endpackage
`default_nettype wire

// *** design/apsc_timer.sv ***
// Saturating phase counter and chip-select-low age counter
`timescale 1ns/100ps
`default_nettype none
module apsc_timer (
  input  wire logic clk,
  input  wire logic rst_n,
  apsc_tmr_if.tmr   t
);
  localparam apsc_pkg::apsc_cnt_t CNT_MAX = 8'hff;

  // Saturation keeps long idle stretches from wrapping into a false match
  wire apsc_pkg::apsc_cnt_t phase_nxt = t.phase_clr ? 8'h00 :
                                        (t.phase == CNT_MAX) ? t.phase : t.phase + 8'h01;
  wire apsc_pkg::apsc_cnt_t age_nxt   = !t.cs_low ? 8'h00 :
                                        (t.age == CNT_MAX) ? t.age : t.age + 8'h01;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      t.phase <= 8'h00;
      t.age   <= 8'h00;
    end else begin
      t.phase <= phase_nxt;
      t.age   <= age_nxt;
    end
  end
endmodule
`default_nettype wire

// *** design/apsc_tmr_if.sv ***
// Carrier between the memory host sequencer and its cycle timer
`timescale 1ns/100ps
`default_nettype none
interface apsc_tmr_if;
  logic                phase_clr;
  logic                cs_low;
  apsc_pkg::apsc_cnt_t phase;
  apsc_pkg::apsc_cnt_t age;
  modport ctrl (output phase_clr, output cs_low, input phase, input age);
  modport tmr  (input phase_clr, input cs_low, output phase, output age);
endinterface
`default_nettype wire
